/* File: wiper_params.svh */
// Constants for the dual up/down wiper counter.
// Assumes inclusion by the package and by the design modules.
`ifndef WIPER_PARAMS_SVH
`define WIPER_PARAMS_SVH
`define WIPER_CODE_W    7
`define WIPER_POSITIONS 128
`define WIPER_ZERO      7'h00
`define WIPER_FULL      7'h7F
`define WIPER_MID       7'h40
`define WIPER_STEP      7'h01
`define MODE_COMMON     1'h0
`define MODE_INDEP      1'h1
`define SEL_CHAN_ONE    1'h0
`define SEL_CHAN_TWO    1'h1
`endif

/* File: wiper_pkg.sv */
// Types for the dual up/down wiper counter.
// Assumes the constants header is in the include path.
`include "wiper_params.svh"
package wiper_pkg;
    typedef logic [`WIPER_CODE_W-1:0] wiper_code_t;
    typedef struct packed {
        logic chip_select_n;
        logic count_clk;
        logic up_down;
        logic mode;
        logic channel_select;
    } ctrl_pins_t;
    typedef struct packed {
        wiper_code_t resistor_channel_one;
        wiper_code_t resistor_channel_two;
    } wiper_pair_t;
endpackage

/* File: wiper_tap_decode.sv */
// One-hot tap decoder for a single resistor string.
// Assumes a code settled within each clock; purely combinational.
`timescale 1ns/1ns
`include "wiper_params.svh"
module wiper_tap_decode
    import wiper_pkg::*;
#(
    parameter int POSITIONS = `WIPER_POSITIONS
) (
    input  wire wiper_code_t          i_code,
    output logic [POSITIONS-1:0]      o_taps
);
    always_comb begin
        o_taps = '0;
        o_taps[i_code] = 1'b1;
    end
endmodule

/* File: dual_updown_wiper_counter.sv */
// Dual 128-position saturating up/down wiper counters and tap decode.
// Assumes asynchronous control pins; all are synchronised to i_core_clk.
// The count clock pin is sampled, so its pulses must be much slower.
//
// Functional notes
// RULE1: Each channel holds a 128-position setting moved only by counted pulses with chip select low.
// RULE2: Counting happens only on a falling count-clock edge; rising edges do nothing.
// RULE3: With chip select low each pulse counts up or down as the direction level says.
// RULE4: Direction high adds one per pulse until the code reaches 7F hex.
// RULE5: Direction low subtracts one per pulse and stops at 00 hex.
// RULE6: Codes saturate at 00 and 7F hex and never wrap.
// RULE7: After reset both codes start at mid-scale 40 hex.
// RULE8: The code drives the tap selection by decode with no extra clocked delay.
// RULE9: The applied tap equals the code, giving code over 128 of the span.
// RULE10: The controller supplies clean, debounced count-clock transitions.
// RULE11: Mode and channel select decide whether one or both channels move.
// RULE12: Common mode moves both codes by the same step, keeping their difference.
// RULE13: Independent mode moves channel one for select low, channel two for high.
// RULE14: Chip select high freezes both codes whatever the other inputs do.
// RULE15: In common mode a step that would overrun either code moves neither.
// RULE16: Direction, mode and select are taken at the counting falling edge.
`timescale 1ns/1ns
`include "wiper_params.svh"
module dual_updown_wiper_counter
    import wiper_pkg::*;
#(
    parameter int POSITIONS = `WIPER_POSITIONS
) (
    input  wire logic                 i_core_clk,
    input  wire logic                 i_resetn,
    input  wire ctrl_pins_t           i_pins,
    output wiper_pair_t               o_wiper_codes,
    output logic [POSITIONS-1:0]      o_taps_one,
    output logic [POSITIONS-1:0]      o_taps_two
);
    ctrl_pins_t  pins_meta_r;
    ctrl_pins_t  pins_sync_r;
    logic        clk_prev_r;
    logic        fall_edge;
    logic        count_en;
    logic        dir_up;
    logic        move_one;
    logic        move_two;
    logic        can_one;
    logic        can_two;
    wiper_code_t code_one_r;
    wiper_code_t code_two_r;
    wiper_code_t code_one_nxt;
    wiper_code_t code_two_nxt;
    logic [POSITIONS-1:0] taps_one_nxt;
    logic [POSITIONS-1:0] taps_two_nxt;

    // True if one step in the given direction stays in range
    function automatic logic step_ok(input wiper_code_t c, input logic up);
        step_ok = up ? (c != `WIPER_FULL) : (c != `WIPER_ZERO);
    endfunction

    function automatic wiper_code_t step(input wiper_code_t c,
                                         input logic up);
        step = up ? c + `WIPER_STEP : c - `WIPER_STEP;
    endfunction

    // Two-stage synchroniser for all pins
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            pins_meta_r <= '{chip_select_n: 1'b1, default: 1'b0};
            pins_sync_r <= '{chip_select_n: 1'b1, default: 1'b0};
        end else begin
            pins_meta_r <= i_pins;
            pins_sync_r <= pins_meta_r;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            clk_prev_r <= 1'b0;
        end else begin
            clk_prev_r <= pins_sync_r.count_clk;
        end
    end

    assign fall_edge = clk_prev_r & ~pins_sync_r.count_clk; // RULE2
    assign count_en  = fall_edge & ~pins_sync_r.chip_select_n; // RULE1 RULE14
    assign dir_up    = pins_sync_r.up_down; // RULE3 RULE16
    assign can_one   = step_ok(code_one_r, dir_up); // RULE6
    assign can_two   = step_ok(code_two_r, dir_up);

    always_comb begin
        move_one = 1'b0;
        move_two = 1'b0;
        if (count_en) begin
            unique case (pins_sync_r.mode) // RULE11
                `MODE_COMMON: begin
                    move_one = can_one & can_two; // RULE12 RULE15
                    move_two = can_one & can_two;
                end
                `MODE_INDEP: begin
                    move_one = can_one &
                        (pins_sync_r.channel_select == `SEL_CHAN_ONE); // RULE13
                    move_two = can_two &
                        (pins_sync_r.channel_select == `SEL_CHAN_TWO);
                end
            endcase
        end
    end

    assign code_one_nxt = move_one ? step(code_one_r, dir_up) // RULE4 RULE5
                                   : code_one_r;
    assign code_two_nxt = move_two ? step(code_two_r, dir_up)
                                   : code_two_r;

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            code_one_r <= `WIPER_MID; // RULE7
            code_two_r <= `WIPER_MID;
        end else begin
            code_one_r <= code_one_nxt;
            code_two_r <= code_two_nxt;
        end
    end

    // Decode from next value so taps track codes in the same edge
    wiper_tap_decode #(.POSITIONS(POSITIONS)) u_dec_one (
        .i_code (code_one_nxt),
        .o_taps (taps_one_nxt)
    );
    wiper_tap_decode #(.POSITIONS(POSITIONS)) u_dec_two (
        .i_code (code_two_nxt),
        .o_taps (taps_two_nxt)
    );

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            o_wiper_codes <= '{`WIPER_MID, `WIPER_MID};
            o_taps_one    <= POSITIONS'(1) << `WIPER_MID;
            o_taps_two    <= POSITIONS'(1) << `WIPER_MID;
        end else begin
            o_wiper_codes <= '{code_one_nxt, code_two_nxt}; // RULE8 RULE9
            o_taps_one    <= taps_one_nxt;
            o_taps_two    <= taps_two_nxt;
        end
    end

    sequence s_fall_sel;
        $fell(pins_sync_r.count_clk) && !pins_sync_r.chip_select_n;
    endsequence

    property p_freeze_cs_high;
        @(posedge i_core_clk) disable iff (!i_resetn)
        pins_sync_r.chip_select_n |=> $stable(code_one_r) && $stable(code_two_r);
    endproperty
    a_freeze_cs_high: assert property (p_freeze_cs_high) // RULE14
        else $error("Code moved with chip select high");

    property p_no_move_without_fall;
        @(posedge i_core_clk) disable iff (!i_resetn)
        !fall_edge |=> $stable(code_one_r) && $stable(code_two_r);
    endproperty
    a_no_move_without_fall: assert property (p_no_move_without_fall) // RULE2
        else $error("Code moved without a falling count edge");

    property p_up_step;
        @(posedge i_core_clk) disable iff (!i_resetn)
        s_fall_sel ##0 (dir_up && pins_sync_r.mode == `MODE_INDEP &&
            !pins_sync_r.channel_select && code_one_r != `WIPER_FULL)
        |=> code_one_r == $past(code_one_r) + `WIPER_STEP;
    endproperty
    a_up_step: assert property (p_up_step) // RULE4
        else $error("Up step did not add one");

    property p_down_step;
        @(posedge i_core_clk) disable iff (!i_resetn)
        s_fall_sel ##0 (!dir_up && pins_sync_r.mode == `MODE_INDEP &&
            pins_sync_r.channel_select && code_two_r != `WIPER_ZERO)
        |=> code_two_r == $past(code_two_r) - `WIPER_STEP;
    endproperty
    a_down_step: assert property (p_down_step) // RULE5
        else $error("Down step did not subtract one");

    property p_no_wrap;
        @(posedge i_core_clk) disable iff (!i_resetn)
        (code_one_r == `WIPER_FULL && dir_up) |=> code_one_r != `WIPER_ZERO;
    endproperty
    a_no_wrap: assert property (p_no_wrap) // RULE6
        else $error("Code wrapped past full scale");

    property p_common_diff;
        @(posedge i_core_clk) disable iff (!i_resetn)
        pins_sync_r.mode == `MODE_COMMON |=>
            (code_one_r - code_two_r) == $past(code_one_r - code_two_r);
    endproperty
    a_common_diff: assert property (p_common_diff) // RULE12
        else $error("Common mode changed the code difference");

    property p_indep_one_only;
        @(posedge i_core_clk) disable iff (!i_resetn)
        pins_sync_r.mode == `MODE_INDEP && !pins_sync_r.channel_select
        |=> $stable(code_two_r);
    endproperty
    a_indep_one_only: assert property (p_indep_one_only) // RULE13
        else $error("Channel two moved while channel one selected");

    property p_common_limit;
        @(posedge i_core_clk) disable iff (!i_resetn)
        s_fall_sel ##0 (pins_sync_r.mode == `MODE_COMMON && dir_up &&
            code_two_r == `WIPER_FULL) |=> $stable(code_one_r);
    endproperty
    a_common_limit: assert property (p_common_limit) // RULE15
        else $error("Common step passed a limit");

    property p_out_tracks;
        @(posedge i_core_clk) disable iff (!i_resetn)
        1'b1 |=> o_wiper_codes.resistor_channel_one == code_one_r &&
            o_taps_one[code_one_r];
    endproperty
    a_out_tracks: assert property (p_out_tracks) // RULE8
        else $error("Output tap does not match code");

    property p_out_tracks_two;
        @(posedge i_core_clk) disable iff (!i_resetn)
        1'b1 |=> o_wiper_codes.resistor_channel_two == code_two_r &&
            o_taps_two[code_two_r];
    endproperty
    a_out_tracks_two: assert property (p_out_tracks_two) // RULE8
        else $error("Channel two tap does not match code");

    property p_common_floor;
        @(posedge i_core_clk) disable iff (!i_resetn)
        s_fall_sel ##0 (pins_sync_r.mode == `MODE_COMMON && !dir_up &&
            code_two_r == `WIPER_ZERO) |=> $stable(code_one_r);
    endproperty
    a_common_floor: assert property (p_common_floor) // RULE15
        else $error("Common step passed the zero limit");

    property p_taps_onehot;
        @(posedge i_core_clk) disable iff (!i_resetn)
        1'b1 |-> $onehot(o_taps_one) && $onehot(o_taps_two);
    endproperty
    a_taps_onehot: assert property (p_taps_onehot) // RULE9
        else $error("Tap selection is not a single position");
endmodule

/* File: pin_driver.sv */
// Push-button side model: one clean count pulse for each request.
// Assumes requests arrive only while o_busy is low.
`timescale 1ns/1ns
module pin_driver
    import wiper_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_req,
    input  wire ctrl_pins_t i_lvl,
    output ctrl_pins_t      o_pins = 5'h10,
    output logic            o_busy
);
    logic [3:0] cnt_r = 4'h0;
    logic       clk_nxt;
    assign o_busy  = (cnt_r != 4'h0);
    assign clk_nxt = o_busy && (cnt_r < 4'h8);
    // Debounced edges: high 7 cycles, then low 8 cycles
    always @(negedge i_core_clk) begin
        if (i_req || o_busy)
            cnt_r <= cnt_r + 4'h1;
        o_pins <= {i_lvl.chip_select_n, clk_nxt, i_lvl[2:0]};
    end
endmodule

/* File: testbench.sv */
// Random and corner-case bench for the dual wiper counter.
// Assumes the pin_driver model supplies all control pins.
`timescale 1ns/1ns
`include "wiper_params.svh"
module testbench
    import wiper_pkg::*;
;
    logic         i_core_clk = 1'h0;
    logic         i_resetn   = 1'h0;
    logic         req        = 1'h0;
    ctrl_pins_t   lvl        = 5'h10;
    ctrl_pins_t   pins;
    logic         busy;
    wiper_pair_t  codes;
    logic [127:0] taps1, taps2;
    wiper_code_t  e1 = `WIPER_MID, e2 = `WIPER_MID;
    logic [31:0]  seed = 32'h84BE;
    int           n_fail = 0, checks = 0, cyc = 0;
    initial forever #25 i_core_clk = ~i_core_clk;
    pin_driver u_pins (.i_core_clk(i_core_clk), .i_req(req),
        .i_lvl(lvl), .o_pins(pins), .o_busy(busy));
    dual_updown_wiper_counter u_dut (.i_core_clk(i_core_clk),
        .i_resetn(i_resetn), .i_pins(pins), .o_wiper_codes(codes),
        .o_taps_one(taps1), .o_taps_two(taps2));
    function automatic logic [31:0] xs(logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic wiper_code_t stp(wiper_code_t c, logic up);
        return up ? c + `WIPER_STEP : c - `WIPER_STEP;
    endfunction
    function automatic wiper_pair_t model(wiper_pair_t c, ctrl_pins_t p);
        wiper_code_t lim;
        logic        m1, m2;
        lim = p.up_down ? `WIPER_FULL : `WIPER_ZERO;
        m1 = c.resistor_channel_one != lim;
        m2 = c.resistor_channel_two != lim;
        if (p.mode == `MODE_COMMON) begin
            m1 = m1 && m2;
            m2 = m1;
        end else begin
            m1 = m1 && (p.channel_select == `SEL_CHAN_ONE);
            m2 = m2 && (p.channel_select == `SEL_CHAN_TWO);
        end
        if (!p.chip_select_n && m1)
            c.resistor_channel_one = stp(c.resistor_channel_one, p.up_down);
        if (!p.chip_select_n && m2)
            c.resistor_channel_two = stp(c.resistor_channel_two, p.up_down);
        return c;
    endfunction
    task automatic cmp_code(string nm, wiper_code_t e, wiper_code_t g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmp_taps(string nm, logic [127:0] e, logic [127:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic check_all();
        cmp_code("code one", e1, codes.resistor_channel_one);
        cmp_code("code two", e2, codes.resistor_channel_two);
        cmp_taps("taps one", 128'h1 << e1, taps1);
        cmp_taps("taps two", 128'h1 << e2, taps2);
    endtask
    task automatic pulse(logic cs_n, logic up, logic md, logic sel);
        int n;
        lvl <= {cs_n, 1'h0, up, md, sel};
        req <= 1'h1;
        @(negedge i_core_clk);
        req <= 1'h0;
        repeat (6) @(negedge i_core_clk);
        cmp_code("after rise", e1, codes.resistor_channel_one);
        n = 0;
        while (busy && n < 40) begin
            @(negedge i_core_clk);
            n++;
        end
        repeat (4) @(negedge i_core_clk);
        {e1, e2} = model({e1, e2}, lvl);
        check_all();
    endtask
    task automatic finish_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Hang guard, well above the expected run length
    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            finish_test();
        end
    end
    initial begin
        repeat (2) @(posedge i_core_clk);
        @(negedge i_core_clk);
        i_resetn <= 1'h1;
        repeat (4) @(negedge i_core_clk);
        check_all();
        repeat (64) pulse(1'h0, 1'h1, `MODE_INDEP, `SEL_CHAN_ONE);
        repeat (66) pulse(1'h0, 1'h0, `MODE_COMMON, 1'h0);
        pulse(1'h0, 1'h0, `MODE_INDEP, `SEL_CHAN_TWO);
        repeat (2) pulse(1'h1, 1'h1, `MODE_INDEP, `SEL_CHAN_ONE);
        repeat (128) pulse(1'h0, 1'h1, `MODE_INDEP, `SEL_CHAN_TWO);
        repeat (2) pulse(1'h0, 1'h1, `MODE_COMMON, 1'h0);
        repeat (300) begin
            seed = xs(seed);
            pulse(seed[0] & seed[1], seed[2], seed[3], seed[4]);
        end
        finish_test();
    end
endmodule
